// file: hdl/sfpp_host.sv
// Host controller that loads, reads and toggle-polls a sector flash
`timescale 1ns/10ps
module sfpp_host #(
  parameter int unsigned WC_CYC_P = sfpp_pkg::WC_CYC
) (
  input wire logic clk_sys, // System clock
  input wire logic rstn, // Async reset
  input wire logic cmd_valid, // Command offered
  output logic cmd_ready, // Command taken
  input wire sfpp_pkg::sfpp_cmd_t cmd, // Operation, address, data
  output logic rsp_valid, // Answer available
  input wire logic rsp_ready, // Answer taken
  output sfpp_pkg::sfpp_rsp_t rsp, // Read data and flags
  output sfpp_pkg::sfpp_pins_t pins, // Strobes and address
  output logic [7:0] dq_out, // Data driven to memory
  output logic dq_oe_n, // Low while driving data
  input wire logic [7:0] dq_in, // Data from memory
  output logic load_window_open // Byte load window running
);
  import sfpp_pkg::*;

  sfpp_state_t state_ff, nxt_state;
  logic [3:0] cnt_ff, nxt_cnt;
  logic [10:0] blc_ff, nxt_blc;
  logic win_ff, nxt_win;
  logic [SECT_W-1:0] sector_ff, nxt_sector;
  sfpp_cmd_t cur_ff, nxt_cur;
  sfpp_pins_t pins_ff, nxt_pins;
  logic [7:0] dq_ff, nxt_dq, rdata_ff, nxt_rdata;
  logic dq_oe_n_ff, nxt_dq_oe_n;
  logic prev_ff, nxt_prev, stable_ff, nxt_stable;
  logic [1:0] reads_ff, nxt_reads;
  logic [16:0] poll_ff, nxt_poll;
  logic ready_ff, nxt_ready;
  sfpp_rsp_t head_ff, tail_ff, nxt_head, nxt_tail, push_rsp;
  logic hv_ff, tv_ff, nxt_hv, nxt_tv, push;

  wire accept = cmd_valid & ready_ff;
  wire cnt_done = (cnt_ff == 4'h0);
  wire is_load = (cmd.op == OP_LOAD);
  wire is_poll = (cur_ff.op == OP_POLL);
  wire [SECT_W-1:0] cmd_sector = cmd.addr[SECT_LSB +: SECT_W];
  wire sector_bad = win_ff & (cmd_sector != sector_ff);
  wire tmo = (poll_ff >= 17'(WC_CYC_P - 1));
  wire tog_same = (reads_ff != 2'h0) & (dq_in[TOG_BIT] == prev_ff);
  wire poll_again = is_poll & ~stable_ff & ~tmo;
  wire pop = hv_ff & rsp_ready;

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_done ? cnt_ff : cnt_ff - 4'h1;
    nxt_blc = (blc_ff != 11'h000) ? blc_ff - 11'h001 : blc_ff;
    nxt_sector = sector_ff;
    nxt_cur = cur_ff;
    nxt_pins = pins_ff;
    nxt_dq = dq_ff;
    nxt_dq_oe_n = dq_oe_n_ff;
    nxt_rdata = rdata_ff;
    nxt_prev = prev_ff;
    nxt_stable = stable_ff;
    nxt_reads = reads_ff;
    nxt_poll = (state_ff != ST_IDLE && is_poll && !tmo) ? poll_ff + 17'h1
                                                        : poll_ff;
    push = 1'b0;
    push_rsp = '0;
    unique case (state_ff)
      ST_IDLE: if (accept) begin
        nxt_cur = cmd;
        if (is_load && sector_bad) begin
          // Load to a different sector inside a window is refused
          push = 1'b1; // RQ1 RQ5
          push_rsp.refused = 1'b1;
        end else begin
          nxt_pins.addr = cmd.addr; // RQ8
          nxt_reads = 2'h0;
          nxt_stable = 1'b0;
          nxt_poll = 17'h0;
          nxt_state = ST_SETUP;
          if (is_load) begin
            nxt_dq = cmd.data;
            nxt_dq_oe_n = 1'b0;
          end
        end
      end
      ST_SETUP: begin
        nxt_pins.ce_n = 1'b0;
        if (cur_ff.op == OP_LOAD) begin
          nxt_pins.we_n = 1'b0; // RQ2
          nxt_sector = cur_ff.addr[SECT_LSB +: SECT_W]; // RQ1 RQ5
          nxt_blc = BLC_CYC - 11'h001; // RQ4
          nxt_cnt = WP_CYC - 4'h1;
          nxt_state = ST_WLOW;
        end else begin
          nxt_pins.oe_n = 1'b0;
          nxt_cnt = ACC_CYC - 4'h1;
          nxt_state = ST_RLOW;
        end
      end
      ST_WLOW: if (cnt_done) begin
        nxt_pins.we_n = 1'b1;
        nxt_pins.ce_n = 1'b1;
        nxt_cnt = WPH_CYC - 4'h1;
        nxt_state = ST_WHIGH;
      end
      ST_WHIGH: if (cnt_done) begin
        nxt_dq_oe_n = 1'b1;
        push = 1'b1;
        nxt_state = ST_IDLE;
      end
      ST_RLOW: if (cnt_done) begin
        nxt_rdata = dq_in;
        nxt_prev = dq_in[TOG_BIT];
        // First read only seeds the comparison
        nxt_stable = tog_same; // RQ7
        nxt_reads = (reads_ff == 2'h3) ? reads_ff : reads_ff + 2'h1;
        nxt_pins.oe_n = 1'b1;
        nxt_pins.ce_n = 1'b1;
        nxt_cnt = OEHP_CYC - 4'h1; // RQ6
        nxt_state = ST_RHIGH;
      end
      ST_RHIGH: if (cnt_done) begin
        if (poll_again) begin
          nxt_pins.oe_n = 1'b0; // RQ6 RQ8
          nxt_pins.ce_n = 1'b0;
          nxt_cnt = ACC_CYC - 4'h1;
          nxt_state = ST_RLOW;
        end else begin
          push = 1'b1;
          push_rsp.data = rdata_ff;
          push_rsp.timeout = is_poll & ~stable_ff;
          nxt_state = ST_IDLE;
        end
      end
    endcase
    nxt_win = (nxt_blc != 11'h000);
  end

  // Two-entry answer buffer; head feeds the outputs
  always_comb begin
    nxt_head = head_ff;
    nxt_tail = tail_ff;
    nxt_hv = hv_ff;
    nxt_tv = tv_ff;
    if (pop) begin
      nxt_head = tv_ff ? tail_ff : push_rsp;
      nxt_hv = tv_ff | push;
      nxt_tail = push_rsp;
      nxt_tv = tv_ff & push;
    end else if (push) begin
      if (hv_ff) begin
        nxt_tail = push_rsp;
        nxt_tv = 1'b1;
      end else begin
        nxt_head = push_rsp;
        nxt_hv = 1'b1;
      end
    end
    nxt_ready = (nxt_state == ST_IDLE) & ~nxt_tv;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 4'h0;
      blc_ff <= 11'h000;
      win_ff <= 1'b0;
      sector_ff <= '0;
      cur_ff <= '0;
      pins_ff <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0};
      dq_ff <= 8'h00;
      dq_oe_n_ff <= 1'b1;
      rdata_ff <= 8'h00;
      prev_ff <= 1'b0;
      stable_ff <= 1'b0;
      reads_ff <= 2'h0;
      poll_ff <= 17'h0;
      ready_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      blc_ff <= nxt_blc;
      win_ff <= nxt_win;
      sector_ff <= nxt_sector;
      cur_ff <= nxt_cur;
      pins_ff <= nxt_pins;
      dq_ff <= nxt_dq;
      dq_oe_n_ff <= nxt_dq_oe_n;
      rdata_ff <= nxt_rdata;
      prev_ff <= nxt_prev;
      stable_ff <= nxt_stable;
      reads_ff <= nxt_reads;
      poll_ff <= nxt_poll;
      ready_ff <= nxt_ready;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      head_ff <= '0;
      tail_ff <= '0;
      hv_ff <= 1'b0;
      tv_ff <= 1'b0;
    end else begin
      head_ff <= nxt_head;
      tail_ff <= nxt_tail;
      hv_ff <= nxt_hv;
      tv_ff <= nxt_tv;
    end
  end

  assign cmd_ready = ready_ff;
  assign rsp_valid = hv_ff;
  assign rsp = head_ff;
  assign pins = pins_ff;
  assign dq_out = dq_ff;
  assign dq_oe_n = dq_oe_n_ff;
  assign load_window_open = win_ff;

  // Cycles since the last write strobe fall, for checking only
  logic [11:0] since_fall_ff;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) since_fall_ff <= 12'hFFF;
    else if ($fell(pins_ff.we_n)) since_fall_ff <= 12'h000;
    else if (since_fall_ff != 12'hFFF) since_fall_ff <= since_fall_ff + 12'h1;
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  AST_SECTOR_ON_FALL: assert property ( // RQ1
    $fell(pins_ff.we_n) |-> pins_ff.addr[SECT_LSB +: SECT_W] == sector_ff)
    else $error("sector bits differ from latched sector at strobe fall");
  AST_OE_HIGH_LOAD: assert property ( // RQ2
    (!pins_ff.we_n && !pins_ff.ce_n) |-> pins_ff.oe_n && !dq_oe_n_ff)
    else $error("output drive low or data released during load strobe");
  AST_LOAD_GAP: assert property ( // RQ4
    ($fell(pins_ff.we_n) && $past(win_ff)) |-> since_fall_ff < 12'(BLC_CYC))
    else $error("byte load issued after the load window");
  AST_SECTOR_KEPT: assert property ( // RQ5
    ($fell(pins_ff.we_n) && $past(win_ff))
      |-> pins_ff.addr[SECT_LSB +: SECT_W] == $past(sector_ff))
    else $error("sector changed inside a load sequence");
  AST_POLL_HIGH_PHASE: assert property ( // RQ6
    ($rose(pins_ff.oe_n) && is_poll) |-> (pins_ff.oe_n && pins_ff.ce_n) [*2])
    else $error("poll strobe high phase shorter than two cycles");
  AST_POLL_TWO_READS: assert property ( // RQ7
    (state_ff == ST_RHIGH && cnt_done && is_poll && !tmo && !poll_again)
      |-> reads_ff >= 2'h2)
    else $error("poll finished on fewer than two reads");
  AST_POLL_ADDR_FIXED: assert property ( // RQ8
    (is_poll && state_ff != ST_IDLE && $past(state_ff) != ST_IDLE)
      |-> $stable(pins_ff.addr))
    else $error("address moved during toggle polling");
  AST_READ_ACCESS: assert property (
    $fell(pins_ff.oe_n) |-> !pins_ff.oe_n [*2] ##1 pins_ff.oe_n)
    else $error("read strobe width differs from access time");
endmodule : sfpp_host

// file: common/sfpp_pkg.sv
// Constants, types and helpers for the sector flash programming host
// Contract
// RQ1: Every load strobe fall carries the sector on sector_number_bits.
// RQ2: Output drive stays high while write strobe and chip select are low.
// RQ3: Unloaded bytes of a programmed sector end up undefined in the memory.
// RQ4: Each further byte load starts within 150 us of the previous one.
// RQ5: After the unlock code, every write strobe fall keeps the sector number.
// RQ6: Poll pulses keep output drive and chip select high at least 150 ns.
// RQ7: The level of busy_toggle_line on first or last poll read means nothing.
// RQ8: All reads of one toggle polling sequence use the same address.
// RQ9: ID reads: maker code at id_select_line low, part code when high.
// RQ10: Power loss drops identification mode; array reads follow power-up.
// RQ11: The identification exit sequence returns the memory to array reads.
// RQ12: busy_toggle_line inverts on each read while programming, then holds.
// RQ13: The memory programs once the byte_load_window passes without a load.
package sfpp_pkg;
  localparam int CLK_NS = 100;
  localparam int WP_NS = 90;
  localparam int WPH_NS = 100;
  localparam int OEHP_NS = 150;
  localparam int ACC_NS = 200;
  localparam int BLC_US = 150;
  localparam int WC_MS = 10;
  localparam int ADDR_W = 19;
  localparam int DATA_W = 8;
  localparam int SECT_LSB = 8;
  localparam int SECT_W = 11;
  localparam int TOG_BIT = 6;
  localparam int ID_SEL_BIT = 0;

  // Least time in whole cycles, never below one
  function automatic int cyc_min(input int t_ns);
    int c;
    c = (t_ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction : cyc_min

  localparam logic [3:0] WP_CYC = 4'(cyc_min(WP_NS));
  localparam logic [3:0] WPH_CYC = 4'(cyc_min(WPH_NS));
  localparam logic [3:0] OEHP_CYC = 4'(cyc_min(OEHP_NS));
  localparam logic [3:0] ACC_CYC = 4'(cyc_min(ACC_NS));
  // Longest time, rounded down
  localparam logic [10:0] BLC_CYC = 11'((BLC_US * 1000) / CLK_NS);
  localparam int WC_CYC = (WC_MS * 1000000) / CLK_NS;

  localparam logic [1:0] OP_READ = 2'h0;
  localparam logic [1:0] OP_LOAD = 2'h1;
  localparam logic [1:0] OP_POLL = 2'h2;

  typedef struct packed {
    logic [1:0] op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } sfpp_cmd_t;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic timeout;
    logic refused;
  } sfpp_rsp_t;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [ADDR_W-1:0] addr;
  } sfpp_pins_t;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_SETUP = 6'h02,
    ST_WLOW = 6'h04,
    ST_WHIGH = 6'h08,
    ST_RLOW = 6'h10,
    ST_RHIGH = 6'h20
  } sfpp_state_t;
endpackage : sfpp_pkg

// file: tb/sfpp_flash_model.sv
// Behavioural sector flash seen from its pins
`timescale 1ns/10ps
module sfpp_flash_model
  import sfpp_pkg::*;
#(
  parameter logic [7:0] MAKER_ID = 8'h5C, // Arbitrary value
  parameter logic [7:0] PART_ID = 8'h93 // Arbitrary value
) (
  input wire logic clk_sys, // Sampling clock of the model
  input wire sfpp_pkg::sfpp_pins_t pins, // Strobes and address
  input wire logic [7:0] dq, // Data bus level
  output logic [7:0] q // Data driven by the memory
);
  int prog_cyc = 60;
  int win_cnt = 0;
  int busy = 0;
  int junk = 0;
  logic [7:0] mem [int];
  logic [7:0] ld [int];
  logic [10:0] sect = '0;
  logic we_q = 1'b1;
  logic rd_q = 1'b0;
  logic tog = 1'b0;
  logic id_mode = 1'b0;
  logic [18:0] a;
  logic [7:0] v;
  wire rd = !pins.ce_n && !pins.oe_n;
  always @(posedge clk_sys) begin
    junk = junk + 37;
    we_q <= pins.we_n;
    rd_q <= rd;
    if (we_q && !pins.we_n && !pins.ce_n) begin
      sect <= pins.addr[18:8];
      ld[pins.addr] = dq;
      win_cnt <= int'(BLC_CYC);
    end else if (win_cnt > 0) begin
      win_cnt <= win_cnt - 1;
      if (win_cnt == 1) busy <= prog_cyc;
    end
    if (busy == 1) begin
      for (int i = 0; i < 256; i++) begin
        a = {sect, 8'(i)};
        mem[a] = ld.exists(a) ? ld[a] : 8'($urandom);
      end
      ld.delete();
    end
    if (busy > 0) busy <= busy - 1;
    // Array reads unless identification mode is on; off after power-up
    v = mem.exists(pins.addr) ? mem[pins.addr] : 8'hFF;
    if (id_mode) v = pins.addr[ID_SEL_BIT] ? PART_ID : MAKER_ID;
    if (rd && !rd_q && busy > 0) tog = ~tog;
    if (busy > 0) v[6] = tog;
    q <= rd ? v : 8'(junk);
  end
endmodule : sfpp_flash_model

// file: tb/testbench.sv
// Self-checking bench for the sector flash host
`timescale 1ns/10ps
module testbench;
  import sfpp_pkg::*;
  // Arbitrary identification values for the model
  localparam logic [7:0] MAKER_ID = 8'h5C;
  localparam logic [7:0] PART_ID = 8'h93;
  logic clk_sys, rstn, cmd_valid, cmd_ready, rsp_valid, rsp_ready;
  logic dq_oe_n, load_window_open, poll_on;
  sfpp_cmd_t cmd;
  sfpp_rsp_t rsp;
  sfpp_pins_t pins;
  logic [7:0] dq_out, fq, ldat [4];
  wire [7:0] dq_bus = dq_oe_n ? fq : dq_out;
  sfpp_rsp_t exp_q [$];
  bit chk_q [$];
  int err_count = 0, cmp_count = 0, hi = 0;
  logic [10:0] s;
  sfpp_host #(.WC_CYC_P(200)) dut (.clk_sys(clk_sys), .rstn(rstn),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
    .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp(rsp), .pins(pins),
    .dq_out(dq_out), .dq_oe_n(dq_oe_n), .dq_in(dq_bus),
    .load_window_open(load_window_open));
  sfpp_flash_model #(.MAKER_ID(MAKER_ID), .PART_ID(PART_ID)) u_flash (
    .clk_sys(clk_sys), .pins(pins), .dq(dq_bus), .q(fq));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict
  task automatic issue(input logic [1:0] op, input logic [18:0] ad,
      input logic [7:0] d, input sfpp_rsp_t e, input bit chk);
    int n;
    n = 0;
    @(posedge clk_sys);
    #1;
    exp_q.push_back(e);
    chk_q.push_back(chk);
    cmd = '{op, ad, d};
    cmd_valid = 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (cmd_ready !== 1'b1 && n < 5000);
    if (cmd_ready !== 1'b1) begin
      err_count++;
      $display("[FAIL] %0t command never taken", $time);
      give_verdict();
    end else begin
      #1 cmd_valid = 1'b0;
    end
  endtask : issue
  task automatic wait_until_quiet;
    int n;
    n = 0;
    while ((exp_q.size() != 0 || load_window_open !== 1'b0) && n < 3000) begin
      @(posedge clk_sys);
      n++;
    end
    if (exp_q.size() != 0 || load_window_open !== 1'b0) begin
      err_count++;
      $display("[FAIL] %0t bench never went quiet", $time);
      give_verdict();
    end else begin
      #1;
    end
  endtask : wait_until_quiet
  // Answers with random stalls by the receiver
  always @(posedge clk_sys) begin
    if (rstn && rsp_valid === 1'b1 && rsp_ready === 1'b1) begin
      cmp_count++;
      if (exp_q.size() == 0 || (chk_q[0] ? rsp !== exp_q[0] :
          rsp[1:0] !== exp_q[0][1:0])) begin
        err_count++;
        $display("[FAIL] %0t unexpected answer %h", $time, rsp);
      end
      if (exp_q.size() != 0) void'(exp_q.pop_front());
      if (chk_q.size() != 0) void'(chk_q.pop_front());
    end
    #1 rsp_ready = ($urandom_range(0, 3) != 0);
  end
  always @(posedge clk_sys) begin
    if (rstn && !pins.ce_n && !pins.we_n) begin
      cmp_count++;
      if (pins.oe_n !== 1'b1 || load_window_open !== 1'b1) begin
        err_count++;
        $display("[FAIL] %0t output drive or load window wrong", $time);
      end
    end
    if (pins.oe_n === 1'b1) hi++;
    else begin
      if (poll_on && hi > 0 && (hi < OEHP_CYC ||
          pins.addr !== {s, 8'h00})) begin
        err_count++;
        $display("[FAIL] %0t poll high phase or address wrong", $time);
      end
      hi = 0;
    end
  end
  initial begin
    #(20000 * CLK_NS);
    err_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    give_verdict();
  end
  initial begin
    rstn = 1'b0;
    cmd_valid = 1'b0;
    cmd = '0;
    rsp_ready = 1'b0;
    poll_on = 1'b0;
    void'($urandom(32'hd3442643));
    repeat (12) @(posedge clk_sys);
    #1 rstn = 1'b1;
    @(posedge clk_sys);
    #1 s = 11'($urandom_range(0, 2047));
    for (int i = 0; i < 4; i++) begin
      ldat[i] = 8'($urandom);
      issue(OP_LOAD, {s, 8'(i)}, ldat[i], '{8'h00, 1'b0, 1'b0}, 0);
      if (i == 1) issue(OP_LOAD, {~s, 8'h10}, 8'h5A,
          '{8'h00, 1'b0, 1'b1}, 0);
    end
    $display("test load done");
    wait_until_quiet();
    poll_on = 1'b1;
    issue(OP_POLL, {s, 8'h00}, 8'h00, '{ldat[0], 1'b0, 1'b0}, 1);
    wait_until_quiet();
    poll_on = 1'b0;
    $display("test poll done");
    for (int i = 0; i < 4; i++)
      issue(OP_READ, {s, 8'(i)}, 8'h00, '{ldat[i], 1'b0, 1'b0}, 1);
    wait_until_quiet();
    $display("test read done");
    u_flash.id_mode = 1'b1;
    issue(OP_READ, {s, 8'h00}, 8'h00, '{MAKER_ID, 1'b0, 1'b0}, 1);
    issue(OP_READ, {s, 8'h01}, 8'h00, '{PART_ID, 1'b0, 1'b0}, 1);
    wait_until_quiet();
    u_flash.id_mode = 1'b0;
    issue(OP_READ, {s, 8'h01}, 8'h00, '{ldat[1], 1'b0, 1'b0}, 1);
    wait_until_quiet();
    $display("test ident done");
    u_flash.prog_cyc = 1000;
    issue(OP_LOAD, {~s, 8'h00}, 8'h3C, '{8'h00, 1'b0, 1'b0}, 0);
    wait_until_quiet();
    issue(OP_POLL, {~s, 8'h00}, 8'h00, '{8'h00, 1'b1, 1'b0}, 0);
    wait_until_quiet();
    $display("test timeout done");
    give_verdict();
  end
endmodule : testbench
